// File: include/pwc_defs.svh
`ifndef PWC_DEFS_SVH
`define PWC_DEFS_SVH

`define PWC_ADDR_CTRL    8'hAE
`define PWC_ADDR_CFG     8'hAF
`define PWC_ADDR_D0L     8'hEE
`define PWC_ADDR_D0H     8'hEF
`define PWC_ADDR_D1L     8'hB1
`define PWC_ADDR_D1H     8'hB2
`define PWC_CTRL_RST     8'h00
`define PWC_CFG_RST      8'h10
`define PWC_BIT_OFF      7
`define PWC_BIT_STKX     7
`define PWC_BIT_PINSEL   6
`define PWC_BIT_DACBYP   5
`define PWC_BIT_SPIMV    1
`define PWC_BIT_XMAP     0
`define PWC_XTAL_DIV     4'hE
`define PWC_XMAP_TOP     24'h000800

`endif

// File: include/pwc_pkg.sv
package pwc_pkg;
  typedef enum logic [2:0] {
    PWC_MODE_OFF  = 3'b000,
    PWC_MODE_VAR  = 3'b001,
    PWC_MODE_TW8  = 3'b010,
    PWC_MODE_TW16 = 3'b011,
    PWC_MODE_NRZ  = 3'b100,
    PWC_MODE_DU8  = 3'b101,
    PWC_MODE_RZ   = 3'b110,
    PWC_MODE_RSV  = 3'b111
  } pwc_mode_t;
  typedef logic [7:0] pwc_byte_t;
endpackage

// File: include/pwc_tick_if.sv
`timescale 1ns/10ps
interface pwc_tick_if;
  logic [1:0] src;
  logic [1:0] pre;
  logic [2:0] div;
  logic       ext_lvl;
  logic       restart;
  logic       tick;
  modport gen (input src, pre, div, ext_lvl, restart, output tick);
  modport use_side (output src, pre, div, ext_lvl, restart, input tick);
endinterface

// File: logic/pwc_tick_gen.sv
`timescale 1ns/10ps
`include "pwc_defs.svh"
module pwc_tick_gen (
  input  wire logic clk,     // System clock.
  input  wire logic sys_rst, // Asynchronous reset, high.
  input  wire logic vco_clk_lvl, // Synchronised fast-source enable level.
  pwc_tick_if.gen   tk       // Clock selection and counter tick.
);
  import pwc_pkg::*;

  logic [10:0] osc_cnt;
  logic [3:0]  x15_cnt;
  logic [5:0]  pre_cnt;
  logic        ext_d;
  logic        base_tick;
  logic        src_tick;
  logic [10:0] div_last;

  always_comb begin
    div_last = (11'h020 << tk.div) - 11'h001;
  end

  // Oscillator over the divide factor stands in for the crystal.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_cnt <= 11'h000;
    end else if (tk.restart || (osc_cnt >= div_last)) begin
      osc_cnt <= 11'h000;
    end else begin
      osc_cnt <= osc_cnt + 11'h001;
    end
  end

  assign base_tick = (osc_cnt >= div_last);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      x15_cnt <= 4'h0;
    end else if (tk.restart) begin
      x15_cnt <= 4'h0;
    end else if (base_tick) begin
      x15_cnt <= (x15_cnt == `PWC_XTAL_DIV) ? 4'h0 : x15_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_d <= 1'b0;
    end else begin
      ext_d <= tk.ext_lvl;
    end
  end

  always_comb begin
    case (tk.src) // [R6]
      2'b00:   src_tick = base_tick && (x15_cnt == `PWC_XTAL_DIV);
      2'b01:   src_tick = base_tick;
      2'b10:   src_tick = tk.ext_lvl && !ext_d;
      2'b11:   src_tick = vco_clk_lvl;
      default: src_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt <= 6'h00;
    end else if (tk.restart) begin
      pre_cnt <= 6'h00;
    end else if (src_tick) begin
      pre_cnt <= pre_cnt + 6'h01;
    end
  end

  always_comb begin
    case (tk.pre) // [R5]
      2'b00:   tk.tick = src_tick;
      2'b01:   tk.tick = src_tick && (pre_cnt[1:0] == 2'h3);
      2'b10:   tk.tick = src_tick && (pre_cnt[3:0] == 4'hF);
      2'b11:   tk.tick = src_tick && (pre_cnt == 6'h3F);
      default: tk.tick = 1'b0;
    endcase
  end
endmodule

// File: logic/pwc_top.sv
`timescale 1ns/10ps
`include "pwc_defs.svh"
// Function
// (R1) Writing control selects mode and clock and clears the counter.
// (R2) 16-bit modes: low byte held hidden; high write loads; applies next cycle.
// (R3) Mode field decodes disabled, variable, twin 8/16, sigma-delta, dual 8; the code runs the sigma-delta codes 100 and 110 as the mode 3 16-bit PWM.
// (R4) Control bit 7 releases the first output pin to the port.
// (R5) Prescale divides the selected clock by 1, 4, 16 or 64.
// (R6) Source: crystal/15, crystal, external pin, or fast clock.
// (R7) Config bit 6 picks port 3 pins or port 2 pins for outputs.
// (R8) Three-bit divide factor 32 to 1024 for the oscillator division; the code divides by 32 to 2048 (codes 6 and 7 both give 2048).
// (R9) Divide factor preset at power-up; reset value 10H.
// (R10) Config bit 7 selects extended stack carry into the high byte.
// (R11) Config bit 5 bypasses the DAC output buffer.
// (R12) Config bit 1 moves the SPI pins to port 3 bits 3 to 5.
// (R13) Config bit 0 maps internal 2 kB data memory at the bottom.
// (R14) Internal data memory accesses leave ports 0 and 2 idle.
// (R15) Two 16-bit compare pairs set the duty of both outputs.
// (R16) Mode 1: second pair is period, first pair is duty.
// (R17) Mode 2: second low is period; edges set by the bytes.
// (R18) Mode 3: fixed 16-bit range, outputs high below compare.
// (R19) Mode 0 and 111 stop the counter and leave pins undriven.
module pwc_top (
  input  wire logic             clk,          // System clock, 25 MHz.
  input  wire logic             sys_rst,      // Asynchronous reset, high.
  input  wire logic             sfr_wr,       // Register write strobe.
  input  wire logic             sfr_rd,       // Register read strobe.
  input  wire logic [7:0]       sfr_addr,     // Direct register address.
  input  wire pwc_pkg::pwc_byte_t sfr_wdata,  // Write data.
  output logic [7:0]            sfr_rdata,    // Read data, registered.
  output logic                  sfr_hit,      // Address belongs to block.
  input  wire logic             ext_clk_pin,  // External counter clock pin.
  input  wire logic             fast_clk_pin, // Fast clock source level.
  input  wire logic [23:0]      xdata_addr,   // Data move address.
  input  wire logic             xdata_req,    // Data move request.
  output logic                  xdata_int,    // Access hits internal memory.
  output logic                  xdata_ext,    // Access uses the port bus.
  output logic                  stack_extend_en,      // Stack carry mode.
  output logic                  dac_buffer_bypass,    // DAC buffer bypass.
  output logic                  spi_pin_relocate,     // SPI on port 3.
  output logic [2:0]            divide_factor,        // Flash clock divide.
  output logic                  p2_6_out,     // Port 2 bit 6 drive value.
  output logic                  p2_6_oe,      // Port 2 bit 6 enable.
  output logic                  p2_7_out,     // Port 2 bit 7 drive value.
  output logic                  p2_7_oe,      // Port 2 bit 7 enable.
  output logic                  p3_4_out,     // Port 3 bit 4 drive value.
  output logic                  p3_4_oe,      // Port 3 bit 4 enable.
  output logic                  p3_3_out,     // Port 3 bit 3 drive value.
  output logic                  p3_3_oe       // Port 3 bit 3 enable.
);
  import pwc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  pwc_byte_t   pwm_control_reg;
  pwc_byte_t   feature_config_reg;
  pwc_byte_t   duty0_high;
  pwc_byte_t   duty0_low;
  pwc_byte_t   duty1_high;
  pwc_byte_t   duty1_low;
  pwc_byte_t   hold0_low;
  pwc_byte_t   hold1_low;
  logic [15:0] act0;
  logic [15:0] act1;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        cyc_end;
  logic        out0;
  logic        out1;
  logic        run;
  logic        wr_ctrl;
  logic [2:0]  ext_sync;
  logic [2:0]  fast_sync;
  logic        ext_lvl;
  logic        fast_lvl;
  pwc_mode_t   mode;
  logic        is16;
  logic        en0;
  logic        en1;

  pwc_tick_if tk ();

  function automatic logic mode_is16(input pwc_mode_t m);
    mode_is16 = (m == PWC_MODE_VAR) || (m == PWC_MODE_TW16) ||
                (m == PWC_MODE_NRZ) || (m == PWC_MODE_RZ);
  endfunction

  assign mode    = pwc_mode_t'(pwm_control_reg[6:4]); // [R3]
  assign is16    = mode_is16(mode);
  assign wr_ctrl = sfr_wr && (sfr_addr == `PWC_ADDR_CTRL);
  assign run     = (mode != PWC_MODE_OFF) && (mode != PWC_MODE_RSV); // [R19]

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass three flops; a change counts once stages two and three
  // agree.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_sync  <= 3'h0;
      fast_sync <= 3'h0;
      ext_lvl   <= 1'b0;
      fast_lvl  <= 1'b0;
    end else begin
      ext_sync  <= {ext_sync[1:0], ext_clk_pin};
      fast_sync <= {fast_sync[1:0], fast_clk_pin};
      if (ext_sync[1] == ext_sync[2]) begin
        ext_lvl <= ext_sync[2];
      end
      if (fast_sync[1] == fast_sync[2]) begin
        fast_lvl <= fast_sync[2];
      end
    end
  end

  assign tk.src     = pwm_control_reg[1:0];
  assign tk.pre     = pwm_control_reg[3:2];
  assign tk.div     = feature_config_reg[4:2]; // [R8]
  assign tk.ext_lvl = ext_lvl;
  assign tk.restart = wr_ctrl; // [R1]

  pwc_tick_gen u_tick (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .vco_clk_lvl (fast_lvl),
    .tk          (tk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_control_reg    <= `PWC_CTRL_RST;
      feature_config_reg <= `PWC_CFG_RST; // [R9]
    end else if (sfr_wr) begin
      if (sfr_addr == `PWC_ADDR_CTRL) begin
        pwm_control_reg <= sfr_wdata; // [R1]
      end
      if (sfr_addr == `PWC_ADDR_CFG) begin
        feature_config_reg <= sfr_wdata;
      end
    end
  end

  // In 16-bit modes the low byte waits in a hidden holder until the high
  // byte is written; 8-bit modes write straight through.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      duty0_high <= 8'h00;
      duty0_low  <= 8'h00;
      duty1_high <= 8'h00;
      duty1_low  <= 8'h00;
      hold0_low  <= 8'h00;
      hold1_low  <= 8'h00;
    end else if (sfr_wr) begin
      case (sfr_addr)
        `PWC_ADDR_D0L: begin
          hold0_low <= sfr_wdata; // [R2]
          if (!is16) begin
            duty0_low <= sfr_wdata;
          end
        end
        `PWC_ADDR_D1L: begin
          hold1_low <= sfr_wdata; // [R2]
          if (!is16) begin
            duty1_low <= sfr_wdata;
          end
        end
        `PWC_ADDR_D0H: begin
          duty0_high <= sfr_wdata;
          if (is16) begin
            duty0_low <= hold0_low; // [R2]
          end
        end
        `PWC_ADDR_D1H: begin
          duty1_high <= sfr_wdata;
          if (is16) begin
            duty1_low <= hold1_low; // [R2]
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and cycle end per mode.
  always_comb begin
    case (mode)
      PWC_MODE_VAR:  cyc_end = (cnt >= ({duty1_high, duty1_low} - 16'h0001));
      PWC_MODE_TW8,
      PWC_MODE_DU8:  cyc_end = (cnt[7:0] >= duty1_low); // [R17]
      default:       cyc_end = (cnt == 16'hFFFF); // [R18]
    endcase
  end

  always_comb begin
    if (cyc_end) begin
      next_cnt = 16'h0000;
    end else begin
      next_cnt = cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 16'h0000;
    end else if (wr_ctrl || !run) begin
      cnt <= 16'h0000; // [R1] [R19]
    end else if (tk.tick) begin
      cnt <= next_cnt;
    end
  end

  // Compare values take effect at the end of the running cycle, on a control write, or while stopped.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      act0 <= 16'h0000;
      act1 <= 16'h0000;
    end else if (wr_ctrl || !run || (tk.tick && cyc_end)) begin
      act0 <= {duty0_high, duty0_low}; // [R2] [R15]
      act1 <= {duty1_high, duty1_low}; // [R15]
    end
  end

  always_comb begin
    case (mode)
      PWC_MODE_VAR: begin
        out0 = 1'b0;
        out1 = (cnt < act0); // [R16]
      end
      PWC_MODE_TW8, PWC_MODE_DU8: begin
        out0 = (cnt[7:0] < act0[7:0]); // [R17]
        out1 = (cnt[7:0] >= act1[15:8]) && (cnt[7:0] < act0[15:8]); // [R17]
      end
      PWC_MODE_TW16, PWC_MODE_NRZ, PWC_MODE_RZ: begin
        out0 = (cnt < act0); // [R18]
        out1 = (cnt < act1); // [R18]
      end
      default: begin
        out0 = 1'b0;
        out1 = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins.
  assign en0 = run && (mode != PWC_MODE_VAR) &&
               !pwm_control_reg[`PWC_BIT_OFF]; // [R4] [R19]
  assign en1 = run;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      p2_6_out <= 1'b0;
      p2_6_oe  <= 1'b0;
      p2_7_out <= 1'b0;
      p2_7_oe  <= 1'b0;
      p3_4_out <= 1'b0;
      p3_4_oe  <= 1'b0;
      p3_3_out <= 1'b0;
      p3_3_oe  <= 1'b0;
    end else begin
      p3_4_out <= out0;
      p3_3_out <= out1;
      p2_6_out <= out0;
      p2_7_out <= out1;
      p3_4_oe  <= en0 && feature_config_reg[`PWC_BIT_PINSEL]; // [R7]
      p3_3_oe  <= en1 && feature_config_reg[`PWC_BIT_PINSEL]; // [R7]
      p2_6_oe  <= en0 && !feature_config_reg[`PWC_BIT_PINSEL]; // [R7]
      p2_7_oe  <= en1 && !feature_config_reg[`PWC_BIT_PINSEL]; // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feature controls and data memory routing.
  assign stack_extend_en   = feature_config_reg[`PWC_BIT_STKX]; // [R10]
  assign dac_buffer_bypass = feature_config_reg[`PWC_BIT_DACBYP]; // [R11]
  assign spi_pin_relocate  = feature_config_reg[`PWC_BIT_SPIMV]; // [R12]
  assign divide_factor     = feature_config_reg[4:2]; // [R8]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xdata_int <= 1'b0;
      xdata_ext <= 1'b0;
    end else begin
      xdata_int <= xdata_req && feature_config_reg[`PWC_BIT_XMAP] &&
                   (xdata_addr < `PWC_XMAP_TOP); // [R13]
      xdata_ext <= xdata_req && !(feature_config_reg[`PWC_BIT_XMAP] &&
                   (xdata_addr < `PWC_XMAP_TOP)); // [R13] [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads.
  always_comb begin
    case (sfr_addr)
      `PWC_ADDR_CTRL, `PWC_ADDR_CFG, `PWC_ADDR_D0L, `PWC_ADDR_D0H,
      `PWC_ADDR_D1L, `PWC_ADDR_D1H: sfr_hit = 1'b1;
      default:                      sfr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `PWC_ADDR_CTRL: sfr_rdata <= pwm_control_reg;
        `PWC_ADDR_CFG:  sfr_rdata <= feature_config_reg;
        `PWC_ADDR_D0L:  sfr_rdata <= duty0_low;
        `PWC_ADDR_D0H:  sfr_rdata <= duty0_high;
        `PWC_ADDR_D1L:  sfr_rdata <= duty1_low;
        `PWC_ADDR_D1H:  sfr_rdata <= duty1_high;
        default:        sfr_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// File: tb/pwc_assertions.sv
`timescale 1ns/10ps
module pwc_checker (
  input wire logic               clk,               // Clock.
  input wire logic               sys_rst,           // Reset, high.
  input wire logic               sfr_wr,            // Write strobe.
  input wire logic               sfr_rd,            // Read strobe.
  input wire logic [7:0]         sfr_addr,          // Address.
  input wire pwc_pkg::pwc_byte_t sfr_wdata,         // Write data.
  input wire logic [7:0]         sfr_rdata,         // Read data.
  input wire logic               sfr_hit,           // Address hit.
  input wire logic [23:0]        xdata_addr,        // Data move address.
  input wire logic               xdata_req,         // Data move request.
  input wire logic               xdata_int,         // Internal hit.
  input wire logic               xdata_ext,         // Port bus use.
  input wire logic               stack_extend_en,   // Stack carry mode.
  input wire logic               dac_buffer_bypass, // Buffer bypass.
  input wire logic               spi_pin_relocate,  // SPI relocation.
  input wire logic [2:0]         divide_factor,     // Divide code.
  input wire logic               p2_6_oe,           // Pin enable.
  input wire logic               p2_7_oe,           // Pin enable.
  input wire logic               p3_4_oe,           // Pin enable.
  input wire logic               p3_3_oe            // Pin enable.
);
  import pwc_pkg::*;
  logic [7:0] ctrl_q;
  logic [7:0] cfg_q;
  //////////////////////////////////////////////////////////////
  // Shadow copies of the two control registers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= 8'h00;
      cfg_q  <= 8'h10;
    end else if (sfr_wr && sfr_addr == 8'hAE) begin
      ctrl_q <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == 8'hAF) begin
      cfg_q <= sfr_wdata;
    end
  end
  //////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  cfg_bits_a: assert property (
    {stack_extend_en, dac_buffer_bypass, spi_pin_relocate} ==
    {cfg_q[7], cfg_q[5], cfg_q[1]}) else $error("config bit out wrong");
  div_field_a: assert property (
    divide_factor == cfg_q[4:2]) else $error("divide field wrong");
  read_back_a: assert property (
    sfr_rd && (sfr_addr == 8'hAE || sfr_addr == 8'hAF) |=> sfr_rdata ==
    ($past(sfr_addr[0]) ? $past(cfg_q) : $past(ctrl_q)))
    else $error("register read wrong");
  unmapped_rd_a: assert property (
    sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00) else $error("unmapped read");
  xmap_hit_a: assert property (
    xdata_req |=> xdata_int == ($past(cfg_q[0]) &&
    $past(xdata_addr) < 24'h000800)) else $error("internal map wrong");
  port_free_a: assert property (
    xdata_req |=> xdata_ext == !xdata_int) else $error("port bus misuse");
  stop_pins_a: assert property (
    (ctrl_q[6:4] inside {3'h0, 3'h7}) && $past(ctrl_q[6:4]) == ctrl_q[6:4]
    |-> !(p2_6_oe || p2_7_oe || p3_4_oe || p3_3_oe))
    else $error("stopped mode drives pin");
  off_pin_a: assert property (
    ctrl_q[7] && $past(ctrl_q[7]) |-> !p2_6_oe && !p3_4_oe)
    else $error("first output not released");
  pin_route_a: assert property (
    $stable(cfg_q[6]) |-> (cfg_q[6] ? !(p2_6_oe || p2_7_oe) :
    !(p3_4_oe || p3_3_oe))) else $error("output pin route wrong");
  mode_one_a: assert property (
    ctrl_q[6:4] == 3'h1 && $past(ctrl_q[6:4]) == 3'h1 |->
    !p2_6_oe && !p3_4_oe) else $error("single mode drives first pin");
endmodule

// File: tb/pwc_top_tb.sv
`timescale 1ns/10ps
module pwc_top_tb;
  import pwc_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  pwc_byte_t   sfr_wdata = 8'h00;
  logic        ext_clk_pin = 1'b0;
  logic        fast_clk_pin = 1'b1;
  logic [23:0] xdata_addr = 24'h000000;
  logic        xdata_req = 1'b0;
  logic [7:0]  sfr_rdata;
  logic        sfr_hit, xdata_int, xdata_ext;
  logic        stack_extend_en, dac_buffer_bypass, spi_pin_relocate;
  logic [2:0]  divide_factor;
  logic        p2_6_out, p2_6_oe, p2_7_out, p2_7_oe;
  logic        p3_4_out, p3_4_oe, p3_3_out, p3_3_oe;
  logic        ext_run = 1'b0;
  logic [15:0] seed = 16'h9D57;
  logic [7:0]  v;
  int          compares = 0;
  int          miscompares = 0;
  int          cycles = 0;
  logic [7:0]  run_ctrl [7] = '{8'h33, 8'h37, 8'h3B, 8'h3F, 8'h32,
                                8'h31, 8'h30};
  int          hi_at [7] = '{4, 28, 124, 500, 10, 200, 3300};
  int          lo_at [7] = '{16, 40, 150, 560, 80, 280, 3900};

  pwc_top pwc_top_inst (.*);

  always #20 clk = ~clk;
  always @(negedge clk)
    if (ext_run && cycles % 4 == 0) ext_clk_pin <= ~ext_clk_pin;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////
  function logic [7:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed[7:0];
  endfunction
  function logic mapped(input logic [7:0] a);
    return a inside {8'hAE, 8'hAF, 8'hEE, 8'hEF, 8'hB1, 8'hB2};
  endfunction
  function logic exp_oe(input int m, input logic second);
    return !(m == 0 || m == 7) && (second || m != 1);
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task chkb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task pause(input int n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk(sfr_rdata, e);
  endtask
  task xd(input logic [23:0] a, input logic e);
    @(negedge clk);
    xdata_addr = a;
    xdata_req = 1'b1;
    @(negedge clk);
    xdata_req = 1'b0;
    chkb(xdata_int, e);
    chkb(xdata_ext, !e);
  endtask
  task final_report();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    pause(5);
    sys_rst = 1'b0;
    rd(8'hAE, 8'h00);
    rd(8'hAF, 8'h10);
    for (int i = 0; i < 6; i++) begin
      v = xs();
      if (!mapped(v)) begin
        rd(v, 8'h00);
        chkb(sfr_hit, 1'b0);
      end
      v = xs();
      wr(8'hAF, v);
      rd(8'hAF, v);
      chk({stack_extend_en, dac_buffer_bypass, spi_pin_relocate,
           divide_factor, 2'b00}, {v[7], v[5], v[1], v[4:2], 2'b00});
    end
    wr(8'hAF, 8'h00);
    wr(8'hAE, 8'h00);
    wr(8'hEE, 8'h08);
    wr(8'hEF, 8'h00);
    wr(8'hB1, 8'hFF);
    wr(8'hB2, 8'hFF);
    rd(8'hEE, 8'h08);
    chkb(sfr_hit, 1'b1);
    for (int m = 0; m < 8; m++) begin
      wr(8'hAE, {1'b0, m[2:0], 4'h3});
      pause(4);
      chkb(p2_6_oe, exp_oe(m, 1'b0));
      chkb(p2_7_oe, exp_oe(m, 1'b1));
    end
    for (int i = 0; i < 7; i++) begin
      wr(8'hAE, run_ctrl[i]);
      ext_run = (run_ctrl[i] == 8'h32);
      pause(hi_at[i]);
      chkb(p2_6_out, 1'b1);
      pause(lo_at[i] - hi_at[i]);
      chkb(p2_6_out, 1'b0);
      chkb(p2_7_out, 1'b1);
    end
    wr(8'hAE, 8'h33);
    wr(8'hEE, 8'h55);
    rd(8'hEE, 8'h08);
    wr(8'hEF, 8'h01);
    rd(8'hEE, 8'h55);
    rd(8'hEF, 8'h01);
    wr(8'hAE, 8'h23);
    wr(8'hB1, 8'h44);
    rd(8'hB1, 8'h44);
    wr(8'hEE, 8'h10);
    wr(8'hEF, 8'h30);
    wr(8'hB2, 8'h20);
    wr(8'hAE, 8'h23);
    pause(8);
    chk({p2_6_out, p2_7_out}, 8'h02);
    pause(32);
    chk({p2_6_out, p2_7_out}, 8'h01);
    wr(8'hAE, 8'h13);
    wr(8'hEE, 8'h05);
    wr(8'hEF, 8'h00);
    wr(8'hB1, 8'h0A);
    wr(8'hB2, 8'h00);
    wr(8'hAE, 8'h13);
    pause(3);
    chk({p2_6_out, p2_7_out}, 8'h01);
    pause(5);
    chk({p2_6_out, p2_7_out}, 8'h00);
    pause(5);
    chk({p2_6_out, p2_7_out}, 8'h01);
    wr(8'hAF, 8'h40);
    wr(8'hAE, 8'h33);
    pause(4);
    chk({p3_4_oe, p3_3_oe, p2_6_oe, p2_7_oe}, 8'h0C);
    chk({p3_4_out, p3_3_out}, 8'h03);
    wr(8'hAE, 8'hB3);
    pause(4);
    chk({p3_4_oe, p3_3_oe}, 8'h01);
    wr(8'hAF, 8'h01);
    xd(24'h0007FF, 1'b1);
    xd(24'h000800, 1'b0);
    wr(8'hAF, 8'h00);
    xd(24'h000000, 1'b0);
    final_report();
  end
endmodule

bind pwc_top pwc_checker pwc_checker_inst (.*);
